// ===== include/sdc_defs.svh
// Constants for the segment descriptor type checker: type codes, selector slots, reset values.
// Included by every design file; definitions only.
`ifndef SDC_DEFS_SVH
`define SDC_DEFS_SVH

// System descriptor type codes (system/user flag clear)
`define SDC_SYS_UPPER_HALF 4'h0
`define SDC_SYS_TSS16_AVAIL 4'h1
`define SDC_SYS_LDT 4'h2
`define SDC_SYS_TSS16_BUSY 4'h3
`define SDC_SYS_CALL16 4'h4
`define SDC_SYS_TASK_GATE 4'h5
`define SDC_SYS_INT16 4'h6
`define SDC_SYS_TRAP16 4'h7
`define SDC_SYS_TSS_AVAIL 4'h9
`define SDC_SYS_TSS_BUSY 4'hB
`define SDC_SYS_CALL 4'hC
`define SDC_SYS_INT 4'hE
`define SDC_SYS_TRAP 4'hF

// Bit positions inside a user descriptor type code
`define SDC_BIT_EXEC 3
`define SDC_BIT_EXPAND 2
`define SDC_BIT_RW 1

// Selector register slots in the loaded-type table
`define SDC_NUM_SEG 6
`define SDC_SEG_CODE 3'h0
`define SDC_SEG_STACK 3'h1
`define SDC_SEG_DATA_A 3'h2
`define SDC_SEG_DATA_B 3'h3
`define SDC_SEG_DATA_C 3'h4
`define SDC_SEG_DATA_D 3'h5

// Reset value of each table entry: user read/write data segment
`define SDC_RST_DESC 5'h13

`endif

// ===== include/sdc_pkg.sv
// Types shared by the descriptor type checker files.
// Assumes sdc_defs.svh is on the include path.
`default_nettype none

package sdc_pkg;

   // Operation kind supplied by the execution pipeline
   typedef enum logic [3:0] {
      SDC_OP_LOAD_LOCAL    = 4'h0,
      SDC_OP_LOAD_TASK     = 4'h1,
      SDC_OP_LOAD_CODE     = 4'h2,
      SDC_OP_LOAD_STACK    = 4'h3,
      SDC_OP_LOAD_DATA     = 4'h4,
      SDC_OP_FAR_XFER      = 4'h5,
      SDC_OP_GATE_REF      = 4'h6,
      SDC_OP_TASKGATE_REF  = 4'h7,
      SDC_OP_INTERRUPT_BACK_OP_LINK     = 4'h8,
      SDC_OP_FAR_BACK      = 4'h9,
      SDC_OP_VECTOR        = 4'hA,
      SDC_OP_READ          = 4'hB,
      SDC_OP_WRITE         = 4'hC
   } sdc_op_e;

   // Operating mode of the processor
   typedef enum logic [1:0] {
      SDC_MODE_LEGACY = 2'h0,
      SDC_MODE_COMPAT = 2'h1,
      SDC_MODE_64     = 2'h2
   } sdc_mode_e;

   // Reason reported with a fault
   typedef enum logic [1:0] {
      SDC_CAUSE_NONE   = 2'h0,
      SDC_CAUSE_DESC   = 2'h1,
      SDC_CAUSE_REF    = 2'h2,
      SDC_CAUSE_ACCESS = 2'h3
   } sdc_cause_e;

endpackage : sdc_pkg

`default_nettype wire

// ===== rtl/sdc_desc_class.sv
// Combinational classifier of one descriptor from its system/user flag and type code.
// Assumes the caller supplies the current long-mode state.
`default_nettype none

`include "sdc_defs.svh"

module sdc_desc_class
   import sdc_pkg::*;
(
   input wire logic i_user,
   input wire logic [3:0] i_type,
   input wire logic i_long,
   output logic o_code,
   output logic o_code_rd,
   output logic o_data,
   output logic o_data_wr,
   output logic o_ldt,
   output logic o_tss_avail,
   output logic o_tss_any,
   output logic o_call_gate,
   output logic o_int_trap,
   output logic o_task_gate,
   output logic o_sys_ok
);

   logic sys;

   // User segments split on the executable bit
   assign sys = ~i_user;
   assign o_code = i_user & i_type[`SDC_BIT_EXEC];
   assign o_code_rd = o_code & i_type[`SDC_BIT_RW];
   assign o_data = i_user & ~i_type[`SDC_BIT_EXEC];
   assign o_data_wr = o_data & i_type[`SDC_BIT_RW];

   // System kinds; legality per mode is folded into o_sys_ok
   always_comb begin
      o_ldt = 1'b0;
      o_tss_avail = 1'b0;
      o_tss_any = 1'b0;
      o_call_gate = 1'b0;
      o_int_trap = 1'b0;
      o_task_gate = 1'b0;
      o_sys_ok = 1'b0;
      if (sys) begin
         unique case (i_type)
            `SDC_SYS_LDT: begin
               o_ldt = 1'b1;
               o_sys_ok = 1'b1;
            end
            `SDC_SYS_TSS_AVAIL: begin
               o_tss_avail = 1'b1;
               o_tss_any = 1'b1;
               o_sys_ok = 1'b1;
            end
            `SDC_SYS_TSS_BUSY: begin
               o_tss_any = 1'b1;
               o_sys_ok = 1'b1;
            end
            `SDC_SYS_TSS16_AVAIL: begin
               o_tss_avail = 1'b1;
               o_tss_any = 1'b1;
               o_sys_ok = ~i_long;
            end
            `SDC_SYS_TSS16_BUSY: begin
               o_tss_any = 1'b1;
               o_sys_ok = ~i_long;
            end
            `SDC_SYS_CALL: begin
               o_call_gate = 1'b1;
               o_sys_ok = 1'b1;
            end
            `SDC_SYS_CALL16: begin
               o_call_gate = 1'b1;
               o_sys_ok = ~i_long;
            end
            `SDC_SYS_INT, `SDC_SYS_TRAP: begin
               o_int_trap = 1'b1;
               o_sys_ok = 1'b1;
            end
            `SDC_SYS_INT16, `SDC_SYS_TRAP16: begin
               o_int_trap = 1'b1;
               o_sys_ok = ~i_long;
            end
            `SDC_SYS_TASK_GATE: begin
               o_task_gate = 1'b1;
               o_sys_ok = ~i_long;
            end
            // Upper half of an extended descriptor must never pass as a legacy one
            `SDC_SYS_UPPER_HALF: o_sys_ok = 1'b0;
            default: o_sys_ok = 1'b0;
         endcase
      end
   end

endmodule // sdc_desc_class

`default_nettype wire

// ===== rtl/sdc_seg_access.sv
// Table of loaded descriptor types per selector register and the access check against it.
// Assumes updates arrive only after a load has passed its type check.
`default_nettype none

`include "sdc_defs.svh"

module sdc_seg_access
   import sdc_pkg::*;
#(
   parameter int NUM_SEG = `SDC_NUM_SEG
) (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic i_upd,
   input wire logic [2:0] i_upd_idx,
   input wire logic [4:0] i_upd_desc,
   input wire logic [2:0] i_idx,
   input wire logic i_rd,
   input wire logic i_wr,
   input wire logic i_mode64,
   output logic o_fault
);

   logic [4:0] desc_q [NUM_SEG];
   logic [4:0] cur;
   logic is_code;
   logic rw_bit;

   // Table only moves on a passed load, so a faulting load leaves it intact
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         for (int k = 0; k < NUM_SEG; k++) begin
            desc_q[k] <= `SDC_RST_DESC;
         end
      end else if (i_upd && (int'(i_upd_idx) < NUM_SEG)) begin
         desc_q[i_upd_idx] <= i_upd_desc;
      end
   end

   // Out-of-range index reads as the reset type
   assign cur = (int'(i_idx) < NUM_SEG) ? desc_q[i_idx] : `SDC_RST_DESC;
   assign is_code = cur[4] & cur[`SDC_BIT_EXEC];
   assign rw_bit = cur[`SDC_BIT_RW];

   // Legacy access checks; 64-bit mode skips them all and treats data as writable
   always_comb begin
      o_fault = 1'b0;
      if (!i_mode64) begin
         if (i_wr && is_code) begin
            o_fault = 1'b1;
         end
         if (i_wr && !is_code && !rw_bit) begin
            o_fault = 1'b1;
         end
         if (i_rd && is_code && !rw_bit) begin
            o_fault = 1'b1;
         end
      end
   end

endmodule // sdc_seg_access

`default_nettype wire

// ===== rtl/sdc_type_check.sv
// Segment and gate descriptor type checker: judges each request in one cycle.
// Assumes the pipeline holds back any state update until o_done shows no fault.
// Assumes descriptor fields hold steady while i_req is sampled high.
`default_nettype none

`include "sdc_defs.svh"

// Timing seen by the pipeline:
//  - A request is taken on a rising edge with i_req high; all inputs sample there.
//  - The answer comes at the next edge and stands for that one cycle only.
//  - Requests may run back to back every cycle; none is ever refused.
//  - A passed selector load writes the table on the edge it is taken,
//    so an access in the next cycle is judged against the new type.
//  - A failed load leaves the table as it was.
//  - Undefined operation codes answer with a descriptor fault.
//  - Mode code 3 checks like neither long mode nor legacy mode.

module sdc_type_check
   import sdc_pkg::*;
#(
   parameter int NUM_SEG = `SDC_NUM_SEG
) (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic i_req,
   input wire logic [3:0] i_op,
   input wire logic [1:0] i_mode,
   input wire logic [2:0] i_seg_idx,
   input wire logic i_desc_user,
   input wire logic [3:0] i_desc_type,
   input wire logic i_ref_user,
   input wire logic [3:0] i_ref_type,
   output logic o_done,
   output logic o_fault,
   output logic [1:0] o_cause
);

   // Decoded operation and mode
   sdc_op_e op;
   sdc_mode_e mode;
   logic is_long;
   logic is_64;
   logic legacy;

   // Descriptor under test
   logic d_code;
   logic d_code_rd;
   logic d_data;
   logic d_data_wr;
   logic d_ldt;
   logic d_tss_avail;
   logic d_tss_any;
   logic d_call;
   logic d_int_trap;
   logic d_task_gate;
   logic d_sys_ok;
   // Descriptor referenced by a gate; only code and task block kinds matter there
   logic r_code;
   logic r_tss_any;
   logic r_sys_ok;

   // Verdict of each stage
   logic desc_ok;
   logic ref_ok;
   logic acc_fault;
   logic is_access;
   logic pass;
   logic upd;
   logic [2:0] upd_idx;
   sdc_cause_e cause_d;

   // Registered answer
   logic done_q;
   logic fault_q;
   logic [1:0] cause_q;

   // Raw pipeline codes seen through the package types
   assign op = sdc_op_e'(i_op);
   assign mode = sdc_mode_e'(i_mode);

   // Mode decode; code 3 is undefined and refuses the legacy-only targets,
   // since treating it as long mode would reject far more than intended
   always_comb begin
      legacy = 1'b0;
      is_long = 1'b0;
      is_64 = 1'b0;
      unique case (mode)
         SDC_MODE_LEGACY: legacy = 1'b1;
         SDC_MODE_COMPAT: is_long = 1'b1;
         SDC_MODE_64: begin
            is_long = 1'b1;
            is_64 = 1'b1;
         end
         default: legacy = 1'b0;
      endcase
   end

   // The same classifier serves the main and the referenced descriptor
   // Both see the long-mode flag, so 16-bit kinds fail in either role
   sdc_desc_class u_desc_class (
      .i_user(i_desc_user),
      .i_type(i_desc_type),
      .i_long(is_long),
      .o_code(d_code),
      .o_code_rd(d_code_rd),
      .o_data(d_data),
      .o_data_wr(d_data_wr),
      .o_ldt(d_ldt),
      .o_tss_avail(d_tss_avail),
      .o_tss_any(d_tss_any),
      .o_call_gate(d_call),
      .o_int_trap(d_int_trap),
      .o_task_gate(d_task_gate),
      .o_sys_ok(d_sys_ok)
   );

   // Referenced target: a gate may only point at code or at a task block
   sdc_desc_class u_ref_class (
      .i_user(i_ref_user),
      .i_type(i_ref_type),
      .i_long(is_long),
      .o_code(r_code),
      .o_code_rd(),
      .o_data(),
      .o_data_wr(),
      .o_ldt(),
      .o_tss_avail(),
      .o_tss_any(r_tss_any),
      .o_call_gate(),
      .o_int_trap(),
      .o_task_gate(),
      .o_sys_ok(r_sys_ok)
   );

   // Type of the descriptor under test against what the operation allows
   // Reads and writes carry no descriptor; they are judged against the table
   // Undefined operation codes fall to the default and fault as a bad descriptor
   always_comb begin
      desc_ok = 1'b0;
      unique case (op)
         // Explicit loads and task switches share these two kinds
         SDC_OP_LOAD_LOCAL: desc_ok = d_ldt & d_sys_ok;
         SDC_OP_LOAD_TASK: desc_ok = d_tss_any & d_sys_ok;
         SDC_OP_LOAD_CODE: desc_ok = d_code;
         // 64-bit mode sees every data segment as writable
         SDC_OP_LOAD_STACK: desc_ok = is_64 ? d_data : d_data_wr;
         // Readable bit does not matter for code in 64-bit mode
         SDC_OP_LOAD_DATA: desc_ok = d_data | (d_code & (d_code_rd | is_64));
         SDC_OP_FAR_XFER: begin
            desc_ok = d_code
               | (d_call & d_sys_ok)
               | (legacy & d_task_gate)
               | (legacy & d_tss_avail);
         end
         // Gates are judged here; their targets in the next process
         SDC_OP_GATE_REF: desc_ok = (d_call | d_int_trap) & d_sys_ok;
         SDC_OP_TASKGATE_REF: desc_ok = d_task_gate & d_sys_ok;
         // Busy or available task block both qualify as a back-link
         SDC_OP_INTERRUPT_BACK_OP_LINK: desc_ok = d_tss_any & d_sys_ok;
         // Covers the interrupt back target as well
         SDC_OP_FAR_BACK: desc_ok = d_code;
         SDC_OP_VECTOR: desc_ok = (d_int_trap | d_task_gate) & d_sys_ok;
         SDC_OP_READ, SDC_OP_WRITE: desc_ok = 1'b1;
         default: desc_ok = 1'b0;
      endcase
   end

   // Referenced descriptor, only looked at for gate references
   // An illegal gate is reported first, so its target only matters after that
   always_comb begin
      ref_ok = 1'b1;
      unique case (op)
         SDC_OP_GATE_REF: ref_ok = r_code;
         // Either width of task block that the mode allows
         SDC_OP_TASKGATE_REF: ref_ok = r_tss_any & r_sys_ok;
         default: ref_ok = 1'b1;
      endcase
   end

   // Only reads and writes take the table verdict into account
   assign is_access = (op == SDC_OP_READ) || (op == SDC_OP_WRITE);

   // Accesses are judged against the type captured at the last passed load
   // Strobes are qualified by the request, so an idle cycle never faults
   // and never touches the table
   sdc_seg_access #(
      .NUM_SEG(NUM_SEG)
   ) u_seg_access (
      .i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst),
      .i_upd(upd),
      .i_upd_idx(upd_idx),
      .i_upd_desc({i_desc_user, i_desc_type}),
      .i_idx(i_seg_idx),
      .i_rd(i_req && (op == SDC_OP_READ)),
      .i_wr(i_req && (op == SDC_OP_WRITE)),
      .i_mode64(is_64),
      .o_fault(acc_fault)
   );

   // Cause priority: the descriptor itself, then its target, then the access
   // One cause only is reported; a bad gate hides whatever its target would show
   always_comb begin
      if (!desc_ok) begin
         cause_d = SDC_CAUSE_DESC;
      end else if (!ref_ok) begin
         cause_d = SDC_CAUSE_REF;
      end else if (is_access && acc_fault) begin
         cause_d = SDC_CAUSE_ACCESS;
      end else begin
         cause_d = SDC_CAUSE_NONE;
      end
   end

   // A request passes only when no stage objected
   assign pass = (cause_d == SDC_CAUSE_NONE);

   // Only a passed selector load may refresh the table; faulting loads leave it untouched
   // A far transfer through a gate loads the code selector later, at the gate's
   // target, so only a direct code target refreshes the code slot here.
   // Table write and verdict share one edge, so a following access sees the new type.
   always_comb begin
      upd = 1'b0;
      upd_idx = `SDC_SEG_CODE;
      if (i_req && pass) begin
         unique case (op)
            SDC_OP_LOAD_CODE, SDC_OP_FAR_BACK: upd = 1'b1;
            SDC_OP_FAR_XFER: upd = d_code;
            SDC_OP_LOAD_STACK: begin
               upd = 1'b1;
               upd_idx = `SDC_SEG_STACK;
            end
            SDC_OP_LOAD_DATA: begin
               upd = (i_seg_idx >= `SDC_SEG_DATA_A) && (i_seg_idx <= `SDC_SEG_DATA_D);
               upd_idx = i_seg_idx;
            end
            default: upd = 1'b0;
         endcase
      end
   end

   // One answer per request, the cycle after it is taken
   // Nothing is ever refused, so the answer needs no handshake back
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         done_q <= 1'b0;
      end else begin
         done_q <= i_req;
      end
   end

   // Single fault pulse per failing request
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         fault_q <= 1'b0;
      end else begin
         fault_q <= i_req && !pass;
      end
   end

   // Cause is forced to none between requests so a stale value never reads as valid
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cause_q <= SDC_CAUSE_NONE;
      end else begin
         cause_q <= i_req ? cause_d : SDC_CAUSE_NONE;
      end
   end

   // Outputs straight from the flops; each is a one-cycle pulse after its request
   assign o_done = done_q;
   assign o_fault = fault_q;
   assign o_cause = cause_q;

endmodule // sdc_type_check

`default_nettype wire

// ===== test/sdc_pipe_model.sv
// Execution pipeline model: presents one descriptor request per cycle.
// Assumes its tasks are entered just after a falling clock edge.
`default_nettype none

module sdc_pipe_model (
   input wire logic i_mclk,
   input wire logic i_done,
   input wire logic i_fault,
   input wire logic [1:0] i_cause,
   output var logic o_req,
   output var logic [3:0] o_op,
   output var logic [1:0] o_mode,
   output var logic [2:0] o_seg_idx,
   output var logic o_desc_user,
   output var logic [3:0] o_desc_type,
   output var logic o_ref_user,
   output var logic [3:0] o_ref_type
);
   timeunit 1ns;
   timeprecision 1ps;

   // Quiet pipeline at time zero
   initial begin
      {o_req, o_op, o_mode, o_seg_idx} = 10'h000;
      {o_desc_user, o_desc_type, o_ref_user, o_ref_type} = 10'h000;
   end

   // Request is left up so the next call runs back to back; verdict is read a cycle later
   task automatic issue(input logic [3:0] op, input logic [1:0] md, input logic [2:0] ix,
                        input logic [4:0] d, input logic [4:0] r,
                        output logic dn, output logic f, output logic [1:0] c);
      o_req = 1'h1;
      o_op = op;
      o_mode = md;
      o_seg_idx = ix;
      {o_desc_user, o_desc_type} = d;
      {o_ref_user, o_ref_type} = r;
      @(posedge i_mclk);
      @(negedge i_mclk);
      dn = i_done;
      f = i_fault;
      c = i_cause;
   endtask

   // Op and descriptor type are inverted while idle, since a stale descriptor must not matter
   task automatic idle();
      o_req = 1'h0;
      o_op = ~o_op;
      o_desc_type = ~o_desc_type;
   endtask
endmodule // sdc_pipe_model

`default_nettype wire

// ===== test/sdc_type_check_props.sv
// Checker for the descriptor type checker: timing and type verdicts at its ports.
// Assumes it is bound to sdc_type_check and sees only that module's ports.
`default_nettype none

module sdc_type_check_props #(
   parameter int NUM_SEG = 6
) (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic i_req,
   input wire logic [3:0] i_op,
   input wire logic [1:0] i_mode,
   input wire logic [2:0] i_seg_idx,
   input wire logic i_desc_user,
   input wire logic [3:0] i_desc_type,
   input wire logic i_ref_user,
   input wire logic [3:0] i_ref_type,
   input wire logic o_done,
   input wire logic o_fault,
   input wire logic [1:0] o_cause
);
   timeunit 1ns;
   timeprecision 1ps;
   logic pu_q;
   logic [3:0] pt_q;

   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_sys_rst);

   // Descriptor of the request now being answered, so verdicts compare against it
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         pu_q <= 1'h0;
         pt_q <= 4'h0;
      end else begin
         pu_q <= i_desc_user;
         pt_q <= i_desc_type;
      end
   end

   sequence s_take(logic [3:0] op);
      i_req && i_op == op;
   endsequence

   a_done_follows_req: assert property (i_req |=> o_done)
      else $error("no answer one cycle after a request");
   a_quiet_when_idle: assert property (!i_req |=> !o_done && !o_fault && o_cause == 2'h0)
      else $error("answer without a request");
   a_cause_with_fault: assert property (o_done |-> o_fault == (o_cause != 2'h0))
      else $error("fault and cause disagree");
   a_local_load_type: assert property (s_take(4'h0) |=> o_fault == (pu_q || pt_q != 4'h2))
      else $error("local table load verdict wrong");
   a_code_load_type: assert property (s_take(4'h2) |=> o_fault == !(pu_q && pt_q[3]))
      else $error("code selector load verdict wrong");
   a_stack_load_type: assert property (s_take(4'h3) ##0 i_mode != 2'h2
      |=> o_fault == !(pu_q && !pt_q[3] && pt_q[1])) else $error("stack load verdict wrong");
   a_data_load_type: assert property (s_take(4'h4) ##0 i_mode != 2'h2
      |=> o_fault == !(pu_q && (!pt_q[3] || pt_q[1]))) else $error("data load verdict wrong");
   a_far_back_code: assert property (s_take(4'h9) |=> o_fault == !(pu_q && pt_q[3]))
      else $error("far back verdict wrong");
   a_vector_long_gate: assert property (s_take(4'hA) ##0 i_mode inside {2'h1, 2'h2}
      |=> o_fault == (pu_q || !(pt_q inside {4'hE, 4'hF}))) else $error("vector entry wrong");
   a_task_load_compat: assert property (s_take(4'h1) ##0 i_mode == 2'h1
      |=> o_fault == (pu_q || !(pt_q inside {4'h9, 4'hB}))) else $error("task load wrong");
   a_wide_write_free: assert property (s_take(4'hC) ##0 i_mode == 2'h2 |=> !o_fault)
      else $error("write faulted in 64-bit mode");
endmodule // sdc_type_check_props

bind sdc_type_check sdc_type_check_props #(.NUM_SEG(NUM_SEG)) u_props (
   .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_req(i_req), .i_op(i_op), .i_mode(i_mode),
   .i_seg_idx(i_seg_idx), .i_desc_user(i_desc_user), .i_desc_type(i_desc_type),
   .i_ref_user(i_ref_user), .i_ref_type(i_ref_type), .o_done(o_done), .o_fault(o_fault),
   .o_cause(o_cause));

`default_nettype wire

// ===== test/sdc_type_check_test.sv
// Self-checking bench for the descriptor type checker, driven through the pipeline model.
// Assumes the checker file is compiled alongside and binds itself to the design.
`default_nettype none

module sdc_type_check_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [1:0] LEG = 2'h0;
   localparam logic [1:0] CMP = 2'h1;
   localparam logic [1:0] M64 = 2'h2;
   localparam logic [2:0] PASS = 3'h0;
   localparam logic [2:0] F_DESC = 3'h5;
   localparam logic [2:0] F_REF = 3'h6;
   localparam logic [2:0] F_ACC = 3'h7;
   logic mclk = 1'h0;
   logic sys_rst = 1'h1;
   logic req, desc_user, ref_user, done, fault;
   logic [3:0] op, desc_type, ref_type;
   logic [1:0] mode, cause;
   logic [2:0] seg_idx;
   int fails = 0;
   int total_checks = 0;

   sdc_type_check #(.NUM_SEG(6)) uut (.i_mclk(mclk), .i_sys_rst(sys_rst), .i_req(req),
      .i_op(op), .i_mode(mode), .i_seg_idx(seg_idx), .i_desc_user(desc_user),
      .i_desc_type(desc_type), .i_ref_user(ref_user), .i_ref_type(ref_type), .o_done(done),
      .o_fault(fault), .o_cause(cause));
   sdc_pipe_model u_pipe (.i_mclk(mclk), .i_done(done), .i_fault(fault), .i_cause(cause),
      .o_req(req), .o_op(op), .o_mode(mode), .o_seg_idx(seg_idx), .o_desc_user(desc_user),
      .o_desc_type(desc_type), .o_ref_user(ref_user), .o_ref_type(ref_type));

   // 50 MHz clock
   always #10 mclk = ~mclk;

   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic check(input logic [3:0] seen, input logic [3:0] exp, input string what);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // One request; expect holds {fault, cause}. A missing answer ends the run at once
   task automatic try(input logic [3:0] o, input logic [1:0] m, input logic [2:0] ix,
                      input logic [4:0] d, input logic [4:0] r, input logic [2:0] ex);
      logic dn, f;
      logic [1:0] c;
      u_pipe.issue(o, m, ix, d, r, dn, f, c);
      check({3'h0, dn}, 4'h1, "answer");
      if (dn !== 1'h1) begin
         end_sim();
      end else begin
         check({3'h0, f}, {3'h0, ex[2]}, "fault");
         check({2'h0, c}, {2'h0, ex[1:0]}, "cause");
      end
   endtask

   task automatic t_table_regs();
      try(4'h0, LEG, 3'h0, 5'h02, 5'h00, PASS);
      try(4'h0, LEG, 3'h0, 5'h09, 5'h00, F_DESC);
      try(4'h0, CMP, 3'h0, 5'h00, 5'h00, F_DESC);
      try(4'h1, LEG, 3'h0, 5'h01, 5'h00, PASS);
      try(4'h1, CMP, 3'h0, 5'h0B, 5'h00, PASS);
      try(4'h1, CMP, 3'h0, 5'h01, 5'h00, F_DESC);
      try(4'h1, M64, 3'h0, 5'h03, 5'h00, F_DESC);
      try(4'h1, LEG, 3'h0, 5'h19, 5'h00, F_DESC);
   endtask

   task automatic t_seg_loads();
      try(4'h2, LEG, 3'h0, 5'h1A, 5'h00, PASS);
      try(4'h2, CMP, 3'h0, 5'h13, 5'h00, F_DESC);
      try(4'h3, LEG, 3'h1, 5'h11, 5'h00, F_DESC);
      try(4'h3, CMP, 3'h1, 5'h13, 5'h00, PASS);
      try(4'h3, LEG, 3'h1, 5'h1A, 5'h00, F_DESC);
      try(4'h4, LEG, 3'h3, 5'h18, 5'h00, F_DESC);
      try(4'h4, CMP, 3'h4, 5'h1A, 5'h00, PASS);
      try(4'h4, LEG, 3'h5, 5'h02, 5'h00, F_DESC);
      try(4'h3, M64, 3'h1, 5'h11, 5'h00, PASS);
      try(4'h4, M64, 3'h5, 5'h18, 5'h00, PASS);
   endtask

   task automatic t_transfers();
      try(4'h5, LEG, 3'h0, 5'h0C, 5'h00, PASS);
      try(4'h5, LEG, 3'h0, 5'h05, 5'h00, PASS);
      try(4'h5, LEG, 3'h0, 5'h09, 5'h00, PASS);
      try(4'h5, CMP, 3'h0, 5'h09, 5'h00, F_DESC);
      try(4'h5, CMP, 3'h0, 5'h05, 5'h00, F_DESC);
      try(4'h5, CMP, 3'h0, 5'h04, 5'h00, F_DESC);
      try(4'h5, LEG, 3'h0, 5'h13, 5'h00, F_DESC);
      try(4'h6, LEG, 3'h0, 5'h0C, 5'h1A, PASS);
      try(4'h6, CMP, 3'h0, 5'h0E, 5'h13, F_REF);
      try(4'h6, LEG, 3'h0, 5'h0F, 5'h09, F_REF);
      try(4'h6, CMP, 3'h0, 5'h06, 5'h1A, F_DESC);
      try(4'h7, LEG, 3'h0, 5'h05, 5'h09, PASS);
      try(4'h7, LEG, 3'h0, 5'h05, 5'h1A, F_REF);
      try(4'h8, LEG, 3'h0, 5'h0B, 5'h00, PASS);
      try(4'h8, LEG, 3'h0, 5'h02, 5'h00, F_DESC);
      try(4'h9, CMP, 3'h0, 5'h1E, 5'h00, PASS);
      try(4'h9, LEG, 3'h0, 5'h0C, 5'h00, F_DESC);
      try(4'hA, LEG, 3'h0, 5'h05, 5'h00, PASS);
      try(4'hA, LEG, 3'h0, 5'h0C, 5'h00, F_DESC);
      try(4'hA, M64, 3'h0, 5'h0E, 5'h00, PASS);
      try(4'hA, CMP, 3'h0, 5'h07, 5'h00, F_DESC);
      try(4'hD, LEG, 3'h0, 5'h1A, 5'h00, F_DESC);
   endtask

   // Loads then accesses back to back: each access must see the type just loaded
   task automatic t_access();
      try(4'h4, LEG, 3'h2, 5'h11, 5'h00, PASS);
      try(4'hC, LEG, 3'h2, 5'h00, 5'h00, F_ACC);
      try(4'hB, CMP, 3'h2, 5'h00, 5'h00, PASS);
      try(4'h2, LEG, 3'h0, 5'h18, 5'h00, PASS);
      try(4'hB, LEG, 3'h0, 5'h00, 5'h00, F_ACC);
      try(4'hC, CMP, 3'h0, 5'h00, 5'h00, F_ACC);
      try(4'hC, M64, 3'h0, 5'h00, 5'h00, PASS);
      try(4'hB, M64, 3'h0, 5'h00, 5'h00, PASS);
      try(4'hC, M64, 3'h2, 5'h00, 5'h00, PASS);
   endtask

   // Mid-run reset: outputs clear and the table returns to writable data
   task automatic t_reset();
      u_pipe.idle();
      sys_rst = 1'h1;
      @(negedge mclk);
      check({done, fault, cause}, 4'h0, "outputs in reset");
      repeat (2) @(negedge mclk);
      sys_rst = 1'h0;
      try(4'hC, LEG, 3'h0, 5'h00, 5'h00, PASS);
      try(4'hC, LEG, 3'h2, 5'h00, 5'h00, PASS);
      u_pipe.idle();
      @(negedge mclk);
      check({done, fault, cause}, 4'h0, "outputs when idle");
      try(4'h1, 2'h3, 3'h0, 5'h01, 5'h00, PASS);
   endtask

   // Main sequence
   initial begin
      repeat (8) @(posedge mclk);
      @(negedge mclk);
      sys_rst = 1'h0;
      t_table_regs();
      t_seg_loads();
      t_transfers();
      t_access();
      t_reset();
      end_sim();
   end

   // Watchdog against a hang anywhere in the run
   initial begin
      repeat (2000) @(posedge mclk);
      fails++;
      $display("CHECK FAILED at %0t: run did not finish", $time);
      end_sim();
   end
endmodule // sdc_type_check_test

`default_nettype wire
